// File: include/t2crb_consts.svh
// Summary of operation
// - Counting only while run control is set
// - Overflow flag set only without serial clocks
// - Flags cleared by software; writing one forces
// - Trigger edge with enable sets external flag
// - Receive select picks this timer's overflow
// - Transmit select picks this timer's overflow
// - Trigger captures or reloads only when enabled, not baud
// - Select bit chooses internal ticks or pin
// - Timer rate twelve or four clocks
// - Baud timer rate is two clocks
// - Capture copies count into reload registers
// - Reload mode overflow loads reload value
// - Trigger edge forces reload in reload mode
// - Serial clocks force reload, ignore capture select
// - Baud overflow gives shift clock, reloads, no flag
// - Baud mode interrupt only from external flag
// - Overflow output pulses for one clock
// - Count is two byte-wide readable writable registers
// - Reload registers hold capture or reload bytes
`ifndef T2CRB_CONSTS_SVH
`define T2CRB_CONSTS_SVH
`define T2CRB_ADDR_CTL 8'hC8
`define T2CRB_ADDR_RCAP_L 8'hCA
`define T2CRB_ADDR_RCAP_H 8'hCB
`define T2CRB_ADDR_CNT_L 8'hCC
`define T2CRB_ADDR_CNT_H 8'hCD
`define T2CRB_BIT_TF 7
`define T2CRB_BIT_EXF 6
`define T2CRB_BIT_RXSEL 5
`define T2CRB_BIT_TXSEL 4
`define T2CRB_BIT_EXEN 3
`define T2CRB_BIT_RUN 2
`define T2CRB_BIT_CT 1
`define T2CRB_BIT_CPRL 0
`define T2CRB_RST_BYTE 8'h00
`define T2CRB_RST_CTL 6'h00
`define T2CRB_RST_PRE 4'h0
`define T2CRB_DIV12_LAST 4'hB
`define T2CRB_DIV4_LAST 2'h3
`define T2CRB_CNT_MAX 16'hFFFF
`endif

// File: include/t2crb_pkg.sv
package t2crb_pkg;
    // One special function register access
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } t2crb_sfr_req_t;

    // Operating mode decoded from control bits
    typedef enum logic [1:0] {
        T2CRB_OFF = 2'b00,
        T2CRB_CAPTURE = 2'b01,
        T2CRB_RELOAD = 2'b10,
        T2CRB_BAUD = 2'b11
    } t2crb_mode_t;
endpackage : t2crb_pkg

// File: src/t2crb_timer.sv
`timescale 1ns/10ps
`include "t2crb_consts.svh"

module t2crb_timer (
    input wire logic mclk, // CPU clock
    input wire logic rst_n, // Synchronous reset
    input wire t2crb_pkg::t2crb_sfr_req_t sfr, // Register access
    output logic [7:0] sfr_rdata, // Read data
    input wire logic clk_rate_fast, // Rate bit, divide by four
    input wire logic [1:0] serial_mode, // Serial port mode
    input wire logic timer1_ovf, // Other timer overflow
    input wire logic external_count_input, // Count pin
    input wire logic external_trigger_input, // Trigger pin
    output logic overflow_pulse_output, // Overflow pulse
    output logic timer_irq, // Flag request
    output logic rx_shift_clk, // Receive baud clock
    output logic tx_shift_clk // Transmit baud clock
);

    // Register state
    logic [5:0] ctl_q;
    logic tf_q;
    logic exf_q;
    logic [15:0] cnt_q;
    logic [15:0] rcap_q;
    logic [3:0] pre_q;
    logic [7:0] rdata_q;
    logic ovf_pulse_q;
    logic rx_clk_q;
    logic tx_clk_q;

    // Pin synchronisers and edge stage
    logic cnt_s1_q;
    logic cnt_s2_q;
    logic cnt_s3_q;
    logic trg_s1_q;
    logic trg_s2_q;
    logic trg_s3_q;

    // Control bit aliases
    wire run = ctl_q[`T2CRB_BIT_RUN];
    wire ext_en = ctl_q[`T2CRB_BIT_EXEN];
    wire ct_sel = ctl_q[`T2CRB_BIT_CT];
    wire cprl = ctl_q[`T2CRB_BIT_CPRL];
    wire rx_sel = ctl_q[`T2CRB_BIT_RXSEL];
    wire tx_sel = ctl_q[`T2CRB_BIT_TXSEL];
    wire baud = rx_sel | tx_sel;

    // Address decode
    wire sel_ctl = sfr.addr == `T2CRB_ADDR_CTL;
    wire sel_rl = sfr.addr == `T2CRB_ADDR_RCAP_L;
    wire sel_rh = sfr.addr == `T2CRB_ADDR_RCAP_H;
    wire sel_cl = sfr.addr == `T2CRB_ADDR_CNT_L;
    wire sel_ch = sfr.addr == `T2CRB_ADDR_CNT_H;
    wire wr_ctl = sfr.wr & sel_ctl;
    wire wr_rl = sfr.wr & sel_rl;
    wire wr_rh = sfr.wr & sel_rh;
    wire wr_cl = sfr.wr & sel_cl;
    wire wr_ch = sfr.wr & sel_ch;
    wire cnt_wr = wr_cl | wr_ch;
    wire rcap_wr = wr_rl | wr_rh;

    // Mode decode
    t2crb_pkg::t2crb_mode_t mode;
    assign mode = !run ? t2crb_pkg::T2CRB_OFF :
        baud ? t2crb_pkg::T2CRB_BAUD :
        cprl ? t2crb_pkg::T2CRB_CAPTURE : t2crb_pkg::T2CRB_RELOAD;

    // Prescaler taps
    wire tick12 = pre_q == `T2CRB_DIV12_LAST;
    wire tick4 = pre_q[1:0] == `T2CRB_DIV4_LAST;
    wire tick2 = pre_q[0];
    wire tick_time = baud ? tick2 : (clk_rate_fast ? tick4 : tick12);

    // Falling edges from synchronised pins
    wire cnt_fall = cnt_s3_q & ~cnt_s2_q;
    wire trg_fall = trg_s3_q & ~trg_s2_q;

    // Count advance and overflow
    wire tick_src = ct_sel ? cnt_fall : tick_time;
    wire inc = run & tick_src;
    wire ovf = inc & (cnt_q == `T2CRB_CNT_MAX);
    wire trig = ext_en & trg_fall;

    // Per-mode actions
    logic do_cap;
    logic do_reload;
    logic tf_set;
    always_comb begin
        do_cap = 1'b0;
        do_reload = 1'b0;
        tf_set = 1'b0;
        case (mode)
            t2crb_pkg::T2CRB_CAPTURE: begin
                do_cap = trig;
                tf_set = ovf;
            end
            t2crb_pkg::T2CRB_RELOAD: begin
                do_reload = ovf | trig;
                tf_set = ovf;
            end
            t2crb_pkg::T2CRB_BAUD: begin
                do_reload = ovf;
            end
            t2crb_pkg::T2CRB_OFF: begin
                do_cap = trig & ~baud & cprl;
                do_reload = trig & ~baud & ~cprl;
            end
            default: begin
                do_cap = 1'b0;
            end
        endcase
    end

    // Next count: software write wins, then reload, then increment
    logic [15:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (do_reload) begin
            cnt_d = rcap_q;
        end else if (inc) begin
            cnt_d = cnt_q + 16'h0001;
        end
        if (wr_cl) begin
            cnt_d[7:0] = sfr.wdata;
        end
        if (wr_ch) begin
            cnt_d[15:8] = sfr.wdata;
        end
    end

    // Next reload registers: write wins over capture
    logic [15:0] rcap_d;
    always_comb begin
        rcap_d = do_cap ? cnt_q : rcap_q;
        if (wr_rl) begin
            rcap_d[7:0] = sfr.wdata;
        end
        if (wr_rh) begin
            rcap_d[15:8] = sfr.wdata;
        end
    end

    // Flags: hardware set beats software clear
    wire tf_d = tf_set | (wr_ctl ? sfr.wdata[`T2CRB_BIT_TF] : tf_q);
    wire exf_d = trig | (wr_ctl ? sfr.wdata[`T2CRB_BIT_EXF] : exf_q);

    // Read mux, unmapped reads give zero
    wire [7:0] rd_mux = sel_ctl ? {tf_q, exf_q, ctl_q} :
        sel_rl ? rcap_q[7:0] :
        sel_rh ? rcap_q[15:8] :
        sel_cl ? cnt_q[7:0] :
        sel_ch ? cnt_q[15:8] : `T2CRB_RST_BYTE;

    // Serial clock selection for modes one and three
    wire ser_13 = serial_mode[0];
    wire rx_d = ser_13 & (rx_sel ? (ovf & baud) : timer1_ovf);
    wire tx_d = ser_13 & (tx_sel ? (ovf & baud) : timer1_ovf);

    // Pin synchronisers
    always_ff @(posedge mclk) begin
        cnt_s1_q <= external_count_input;
        cnt_s2_q <= cnt_s1_q;
        cnt_s3_q <= cnt_s2_q;
        trg_s1_q <= external_trigger_input;
        trg_s2_q <= trg_s1_q;
        trg_s3_q <= trg_s2_q;
    end

    // Prescaler divides by twelve
    always_ff @(posedge mclk) begin
        if (!rst_n || tick12) begin
            pre_q <= `T2CRB_RST_PRE;
        end else begin
            pre_q <= pre_q + 4'h1;
        end
    end

    // Control, flags and count registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl_q <= `T2CRB_RST_CTL;
            tf_q <= 1'b0;
            exf_q <= 1'b0;
            cnt_q <= {`T2CRB_RST_BYTE, `T2CRB_RST_BYTE};
            rcap_q <= {`T2CRB_RST_BYTE, `T2CRB_RST_BYTE};
        end else begin
            ctl_q <= wr_ctl ? sfr.wdata[5:0] : ctl_q;
            tf_q <= tf_d;
            exf_q <= exf_d;
            cnt_q <= cnt_d;
            rcap_q <= rcap_d;
        end
    end

    // Registered outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= `T2CRB_RST_BYTE;
            ovf_pulse_q <= 1'b0;
            rx_clk_q <= 1'b0;
            tx_clk_q <= 1'b0;
        end else begin
            rdata_q <= sfr.rd ? rd_mux : rdata_q;
            ovf_pulse_q <= ovf;
            rx_clk_q <= rx_d;
            tx_clk_q <= tx_d;
        end
    end

    // Output drive
    assign sfr_rdata = rdata_q;
    assign overflow_pulse_output = ovf_pulse_q;
    assign timer_irq = tf_q | exf_q;
    assign rx_shift_clk = rx_clk_q;
    assign tx_shift_clk = tx_clk_q;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_RUN_STOP: assert property (
        (!run && !cnt_wr && !trig) |=> $stable(cnt_q))
        else $error("count moved while stopped");

    AST_TF_SET: assert property (
        (ovf && !baud) |=> tf_q)
        else $error("overflow flag not set");

    AST_TF_BAUD: assert property (
        (baud && !wr_ctl && !tf_q) |=> !tf_q)
        else $error("overflow flag set in baud mode");

    AST_EXF_SET: assert property (
        (ext_en && trg_fall) |=> exf_q)
        else $error("external flag not set");

    AST_NO_HW_CLR: assert property (
        ((tf_q || exf_q) && !wr_ctl) |=> (tf_q >= $past(tf_q)) && (exf_q >= $past(exf_q)))
        else $error("flag cleared by hardware");

    AST_CAPTURE: assert property (
        (run && cprl && !baud && trig && !rcap_wr) |=> rcap_q == $past(cnt_q))
        else $error("capture value wrong");

    AST_RELOAD: assert property (
        (ovf && !cprl && !cnt_wr) |=> cnt_q == $past(rcap_q))
        else $error("reload value wrong");

    AST_PULSE: assert property (
        ovf |=> overflow_pulse_output ##1 !overflow_pulse_output)
        else $error("overflow pulse width wrong");

    AST_RX_SEL: assert property (
        (ser_13 && rx_sel && ovf) |=> rx_shift_clk)
        else $error("receive clock missing");

    AST_BAUD_IRQ: assert property (
        (baud && !wr_ctl && !exf_q && !tf_q && !trig) |=> !timer_irq)
        else $error("interrupt without trigger in baud mode");

    COV_CAPTURE: cover property (do_cap);
    COV_RELOAD_OVF: cover property (ovf && !baud && !cprl);
    COV_BAUD_TX: cover property (tx_shift_clk && tx_sel);
    COV_TRIG_RELOAD: cover property (trig && mode == t2crb_pkg::T2CRB_RELOAD);

endmodule : t2crb_timer

// File: tb/t2crb_pins_model.sv
`timescale 1ns/10ps

module t2crb_pins_model (
    input wire logic mclk, // CPU clock
    input wire logic trig_req, // One trigger fall wanted
    input wire logic cnt_req, // One count pulse wanted
    output logic external_count_input, // Count pin
    output logic external_trigger_input // Trigger pin
);
    logic [2:0] trig_q = 3'h0;
    logic [2:0] cnt_q = 3'h0;

    // Each request pulls its pin low four cycles, idle level high
    always @(posedge mclk) begin
        trig_q <= trig_req ? 3'h4 : trig_q - {2'h0, trig_q != 3'h0};
        cnt_q <= cnt_req ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
    end

    // Pins low only while a request is being served
    assign external_trigger_input = (trig_q == 3'h0);
    assign external_count_input = (cnt_q == 3'h0);
endmodule : t2crb_pins_model

// File: tb/tb_top.sv
`timescale 1ns/10ps

module tb_top;
    typedef struct packed {
        logic [2:0] op;
        logic [7:0] addr;
        logic [7:0] data;
    } t2crb_row_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    t2crb_pkg::t2crb_sfr_req_t sfr = '0;
    logic clk_rate_fast = 1'b0;
    logic [1:0] serial_mode = 2'h0;
    logic timer1_ovf = 1'b0;
    logic trig_req = 1'b0;
    logic cnt_req = 1'b0;
    logic [7:0] sfr_rdata;
    logic ovf_out, irq, rx_clk, tx_clk, cnt_pin, trig_pin;
    int bad_count = 0;
    int n_compared = 0;
    int cyc;
    wire logic [3:0] outs = {tx_clk, rx_clk, ovf_out, irq};
    // Ops: 0 write, 1 read, 2 trigger fall, 3 count pulse, 4 interrupt level check
    t2crb_row_t rows [$] = '{
        '{3'h1, 8'hC8, 8'h00}, '{3'h1, 8'hCA, 8'h00}, '{3'h1, 8'hCD, 8'h00},
        '{3'h0, 8'hC9, 8'hFF}, '{3'h1, 8'hC9, 8'h00}, '{3'h0, 8'hCA, 8'h12},
        '{3'h0, 8'hCB, 8'h34}, '{3'h1, 8'hCA, 8'h12}, '{3'h1, 8'hCB, 8'h34},
        '{3'h0, 8'hCC, 8'h34}, '{3'h0, 8'hCD, 8'h12}, '{3'h0, 8'hC8, 8'h0F},
        '{3'h2, 8'h00, 8'h00}, '{3'h1, 8'hCA, 8'h34}, '{3'h1, 8'hCB, 8'h12},
        '{3'h4, 8'h00, 8'h01}, '{3'h1, 8'hC8, 8'h4F}, '{3'h0, 8'hC8, 8'h00},
        '{3'h4, 8'h00, 8'h00}, '{3'h0, 8'hC8, 8'h01}, '{3'h2, 8'h00, 8'h00},
        '{3'h4, 8'h00, 8'h00}, '{3'h1, 8'hCA, 8'h34}, '{3'h0, 8'hCA, 8'hCD},
        '{3'h0, 8'hCB, 8'hAB}, '{3'h0, 8'hC8, 8'h08}, '{3'h2, 8'h00, 8'h00},
        '{3'h1, 8'hCC, 8'hCD}, '{3'h1, 8'hCD, 8'hAB}, '{3'h0, 8'hC8, 8'h80},
        '{3'h4, 8'h00, 8'h01}, '{3'h1, 8'hC8, 8'h80}, '{3'h0, 8'hC8, 8'h00},
        '{3'h0, 8'hCC, 8'h00}, '{3'h0, 8'hCD, 8'h00}, '{3'h0, 8'hC8, 8'h06},
        '{3'h3, 8'h00, 8'h00}, '{3'h3, 8'h00, 8'h00}, '{3'h3, 8'h00, 8'h00},
        '{3'h1, 8'hCC, 8'h03}, '{3'h0, 8'hC8, 8'h02}, '{3'h3, 8'h00, 8'h00},
        '{3'h1, 8'hCC, 8'h03}, '{3'h1, 8'hCD, 8'h00}
    };

    t2crb_timer u_dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .sfr(sfr),
        .sfr_rdata(sfr_rdata),
        .clk_rate_fast(clk_rate_fast),
        .serial_mode(serial_mode),
        .timer1_ovf(timer1_ovf),
        .external_count_input(cnt_pin),
        .external_trigger_input(trig_pin),
        .overflow_pulse_output(ovf_out),
        .timer_irq(irq),
        .rx_shift_clk(rx_clk),
        .tx_shift_clk(tx_clk)
    );

    t2crb_pins_model u_pins (
        .mclk(mclk),
        .trig_req(trig_req),
        .cnt_req(cnt_req),
        .external_count_input(cnt_pin),
        .external_trigger_input(trig_pin)
    );

    // Free-running CPU clock
    initial begin
        forever #25 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge mclk);
        sfr <= '0;
        @(posedge mclk);
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge mclk);
        sfr <= '0;
        #1;
        check(sfr_rdata, exp);
        @(posedge mclk);
    endtask : sfr_rd

    task automatic pin_evt(input logic trig);
        if (trig) begin
            trig_req <= 1'b1;
        end else begin
            cnt_req <= 1'b1;
        end
        @(posedge mclk);
        trig_req <= 1'b0;
        cnt_req <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : pin_evt

    // Cycles until the chosen output is next seen high
    task automatic wait_pulse(input int src, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (outs[src] !== 1'b1 && n < 200);
        if (n >= 200) begin
            bad_count++;
            test_done();
        end
    endtask : wait_pulse

    // Script rows, then period and serial clock cases
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            case (rows[i].op)
                3'h0: sfr_wr(rows[i].addr, rows[i].data);
                3'h1: sfr_rd(rows[i].addr, rows[i].data);
                3'h2: pin_evt(1'b1);
                3'h3: pin_evt(1'b0);
                default: check({7'h0, irq}, {7'h0, rows[i].data[0]});
            endcase
        end
        sfr_wr(8'hCA, 8'hFF);
        sfr_wr(8'hCB, 8'hFF);
        sfr_wr(8'hCC, 8'hFF);
        sfr_wr(8'hCD, 8'hFF);
        sfr_wr(8'hC8, 8'h04);
        wait_pulse(1, cyc);
        wait_pulse(1, cyc);
        check(cyc[7:0], 8'h0C);
        check({7'h0, irq}, 8'h01);
        @(posedge mclk);
        clk_rate_fast <= 1'b1;
        wait_pulse(1, cyc);
        wait_pulse(1, cyc);
        check(cyc[7:0], 8'h04);
        @(posedge mclk);
        sfr_wr(8'hC8, 8'h00);
        serial_mode <= 2'h1;
        sfr_wr(8'hC8, 8'h34);
        wait_pulse(2, cyc);
        wait_pulse(2, cyc);
        check(cyc[7:0], 8'h02);
        wait_pulse(3, cyc);
        wait_pulse(3, cyc);
        check(cyc[7:0], 8'h02);
        check({7'h0, irq}, 8'h00);
        @(posedge mclk);
        sfr_wr(8'hC8, 8'h2D);
        wait_pulse(2, cyc);
        wait_pulse(2, cyc);
        check(cyc[7:0], 8'h02);
        @(posedge mclk);
        pin_evt(1'b1);
        check({7'h0, irq}, 8'h01);
        sfr_wr(8'hC8, 8'h00);
        timer1_ovf <= 1'b1;
        @(posedge mclk);
        timer1_ovf <= 1'b0;
        #1;
        check({6'h0, rx_clk, tx_clk}, 8'h03);
        // Mid-run reset clears control, flags and reload bytes
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        sfr_rd(8'hC8, 8'h00);
        sfr_rd(8'hCB, 8'h00);
        check({7'h0, irq}, 8'h00);
        test_done();
    end
endmodule : tb_top
